// ===== design/fsc_cfg.svh
// Purpose: constants for the flash status/config link pair
// Assumes: pclk at 200 MHz, link clock made by the host end
// Notes: offsets, field positions, resets and timing counts
`ifndef FSC_CFG_SVH
`define FSC_CFG_SVH

// opcodes
`define FSC_OP_WREN 8'h06
`define FSC_OP_WRDI 8'h04
`define FSC_OP_RD1 8'h05
`define FSC_OP_RD2 8'h35
`define FSC_OP_RD3 8'h15
`define FSC_OP_WR1 8'h01
`define FSC_OP_WR2 8'h31
`define FSC_OP_WR3 8'h11
`define FSC_OP_SUSP 8'h75
`define FSC_OP_RESUME 8'h7A
`define FSC_OP_QUAD_ON 8'h38
`define FSC_OP_QUAD_OFF 8'hFF
`define FSC_OP_PFX1 8'hAA
`define FSC_OP_PFX2 8'h55
`define FSC_OP_ADDR4 8'hB7
`define FSC_OP_ADDR3 8'hE9
// field positions
`define FSC_SR1_GUARD 7
`define FSC_SR1_LATCH 1
`define FSC_SR2_PAUSE 7
`define FSC_SR2_LOCK_LO 3
`define FSC_SR2_FOUR 1
`define FSC_SR2_SUPPLY 0
`define FSC_SR3_ACT_W 0
`define FSC_SR3_PON_W 1
`define FSC_SR3_DUMMY_LO 2
`define FSC_SR3_STR_LO 5
`define FSC_SR3_PINSEL 7
// reset values and dummy counts
`define FSC_STR_RST 2'h1
`define FSC_DUMMY_RST 2'h0
`define FSC_DUMMY_8 4'h8
`define FSC_DUMMY_4 4'h4
`define FSC_DUMMY_6 4'h6
`define FSC_DUMMY_10 4'hA
// frame sizes in link bits
`define FSC_BITS_OP 5'h08
`define FSC_BITS_WR 5'h10
// host register offsets and fields
`define FSC_REG_CMD 8'h00
`define FSC_REG_STAT 8'h04
`define FSC_REG_PINS 8'h08
`define FSC_CMD_DATA 8
`define FSC_CMD_LONG 16
// link timing
`define FSC_PCLK_NS 5
`define FSC_SCK_NS 80
`define FSC_SCK_HALF (`FSC_SCK_NS / `FSC_PCLK_NS / 2)
`endif

// ===== design/fsc_pkg.sv
// Purpose: shared types for the flash status/config link pair
// Assumes: constants live in fsc_cfg.svh
// Notes: types only
package fsc_pkg;
   typedef enum logic [1:0] {
      FSC_IDLE = 2'b00,
      FSC_SHIFT = 2'b01,
      FSC_TAIL = 2'b10
   } fsc_host_st_e;
endpackage

// ===== design/fsc_link_if.sv
// Purpose: serial link between host controller and flash end
// Assumes: all wires one-way, link clock made by the host
// Notes: io2/io3 roles appear as guard_n and pause_n
`timescale 1ns/1ps
interface fsc_link_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic miso;
   logic guard_n;
   logic pause_n;
   modport dev (input sck, cs_n, mosi, guard_n, pause_n, output miso);
   modport host (output sck, cs_n, mosi, guard_n, pause_n, input miso);
endinterface

// ===== design/fsc_sync.sv
// Purpose: two-stage synchroniser bank for pins
// Assumes: each bit an independent level
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module fsc_sync #(parameter int W = 1) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pins in, levels out
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;
   // double flop per bit
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            meta_q[i] <= 1'b1;
            dout[i] <= 1'b1;
         end else begin
            meta_q[i] <= din[i];
            dout[i] <= meta_q[i];
         end
      end
   end
endmodule // fsc_sync

// ===== design/fsc_device.sv
// Purpose: flash end: status/config bits behind the serial link
// Assumes: presetn is the power cycle; link pins asynchronous
// Notes: data moves on one line in every mode
`timescale 1ns/1ps
`include "fsc_cfg.svh"
module fsc_device (
   // clock and power reset
   input wire logic pclk,
   input wire logic presetn,
   // link
   fsc_link_if.dev link,
   // secure area access check
   input wire logic [1:0] sec_area_sel,
   input wire logic sec_wr_req,
   output logic sec_wr_refused,
   // configuration seen by the array logic
   output logic [1:0] drive_strength,
   output logic four_byte_addr,
   output logic four_line_en,
   output logic quad_cmd_mode,
   output logic [3:0] dummy_fast,
   output logic [3:0] dummy_dual_io,
   output logic [3:0] dummy_quad_io,
   output logic write_cycle_start
);
   logic sck_s, cs_n_s, mosi_s, guard_n_s, pause_n_s;
   logic sck_prev_q, cs_prev_q;
   logic [4:0] bit_cnt_q;
   logic [15:0] rx_q;
   logic [7:0] tx_q;
   logic miso_q;
   logic latch_q, guard_q, supply_q, otp_q, pause_q, four_q, quad_q;
   logic [2:0] locks_q;
   logic act_w_q, pon_w_q, pinsel_q;
   logic [1:0] str_q, dummy_q;
   logic [1:0] pfx_q;
   logic hold_fn, paused, pin_rst, rise, fall, frame_end;
   logic single, long_frm, wr_cmd, wr_ok, commit;
   logic [7:0] op, data, sr1, sr2, sr3, rd_op;

   fsc_sync #(.W(5)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din({link.sck, link.cs_n, link.mosi, link.guard_n, link.pause_n}),
      .dout({sck_s, cs_n_s, mosi_s, guard_n_s, pause_n_s})
   );

   // shared pin roles follow four-line enable and pin select
   assign hold_fn = ~four_q & ~pinsel_q;
   assign paused = hold_fn & ~pause_n_s;
   assign pin_rst = ~four_q & pinsel_q & ~pause_n_s;
   // edges are ignored while paused or in pin reset
   assign rise = sck_s & ~sck_prev_q & ~cs_n_s & ~paused & ~pin_rst;
   assign fall = ~sck_s & sck_prev_q & ~cs_n_s & ~paused & ~pin_rst;
   assign frame_end = cs_n_s & ~cs_prev_q & ~pin_rst;

   // decode the finished frame
   assign single = frame_end & (bit_cnt_q == `FSC_BITS_OP);
   assign long_frm = frame_end & (bit_cnt_q == `FSC_BITS_WR);
   assign op = long_frm ? rx_q[15:8] : rx_q[7:0];
   assign data = rx_q[7:0];
   assign wr_cmd = long_frm & (op == `FSC_OP_WR1 || op == `FSC_OP_WR2 || op == `FSC_OP_WR3);
   // guard pin only matters in plain or dual line mode with pins not data
   assign wr_ok = latch_q & ~supply_q & ~otp_q
      & ~(guard_q & ~guard_n_s & ~quad_q & ~four_q);
   assign commit = wr_cmd & wr_ok;

   // readback images, reserved bits read zero
   always_comb begin
      sr1 = 8'h00;
      sr1[`FSC_SR1_GUARD] = guard_q;
      sr1[`FSC_SR1_LATCH] = latch_q;
      sr2 = 8'h00;
      sr2[`FSC_SR2_PAUSE] = pause_q;
      sr2[`FSC_SR2_LOCK_LO +: 3] = locks_q;
      sr2[`FSC_SR2_FOUR] = four_q;
      sr2[`FSC_SR2_SUPPLY] = supply_q;
      sr3 = 8'h00;
      sr3[`FSC_SR3_ACT_W] = act_w_q;
      sr3[`FSC_SR3_PON_W] = pon_w_q;
      sr3[`FSC_SR3_DUMMY_LO +: 2] = dummy_q;
      sr3[`FSC_SR3_STR_LO +: 2] = str_q;
      sr3[`FSC_SR3_PINSEL] = pinsel_q;
   end

   // opcode as it completes on the eighth rising edge
   assign rd_op = {rx_q[6:0], mosi_s};

   // serial shift engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
         bit_cnt_q <= 5'h00;
         rx_q <= 16'h0000;
         tx_q <= 8'h00;
         miso_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_s;
         cs_prev_q <= cs_n_s;
         if (cs_n_s || pin_rst) begin
            bit_cnt_q <= 5'h00;
         end else if (rise) begin
            rx_q <= {rx_q[14:0], mosi_s};
            if (bit_cnt_q != 5'h1F) begin
               bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            if (bit_cnt_q == `FSC_BITS_OP - 5'h01) begin
               unique case (rd_op)
                  `FSC_OP_RD1: tx_q <= sr1;
                  `FSC_OP_RD2: tx_q <= sr2;
                  `FSC_OP_RD3: tx_q <= sr3;
                  default: tx_q <= 8'h00;
               endcase
            end
         end else if (fall && bit_cnt_q >= `FSC_BITS_OP) begin
            miso_q <= tx_q[7]; // shift out on falling edges
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end
   assign link.miso = miso_q;

   // write latch: set by enable, cleared by disable or a taken write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q <= 1'b0;
      end else if (pin_rst) begin
         latch_q <= 1'b0;
      end else if (single && op == `FSC_OP_WREN) begin
         latch_q <= 1'b1;
      end else if ((single && op == `FSC_OP_WRDI) || commit) begin
         latch_q <= 1'b0;
      end
   end

   // protection bits; the supply lock only clears with power
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         guard_q <= 1'b0;
         supply_q <= 1'b0;
         otp_q <= 1'b0;
      end else if (commit) begin
         if (op == `FSC_OP_WR1) begin
            guard_q <= data[`FSC_SR1_GUARD];
         end
         if (op == `FSC_OP_WR2) begin
            supply_q <= data[`FSC_SR2_SUPPLY];
         end
         if (pfx_q == 2'h2) begin
            otp_q <= 1'b1;
         end
      end
   end

   // prefix tracker: AA then 55 arms the next status write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pfx_q <= 2'h0;
      end else if (pin_rst) begin
         pfx_q <= 2'h0;
      end else if (single && op == `FSC_OP_PFX1) begin
         pfx_q <= 2'h1;
      end else if (single && op == `FSC_OP_PFX2 && pfx_q == 2'h1) begin
         pfx_q <= 2'h2;
      end else if (single && op == `FSC_OP_WREN) begin
         pfx_q <= pfx_q; // enable may sit between prefix and write
      end else if (frame_end) begin
         pfx_q <= 2'h0;
      end
   end

   // pause flag follows suspend and resume
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pause_q <= 1'b0;
      end else if (pin_rst) begin
         pause_q <= 1'b0;
      end else if (single && op == `FSC_OP_SUSP) begin
         pause_q <= 1'b1;
      end else if (single && op == `FSC_OP_RESUME) begin
         pause_q <= 1'b0;
      end
   end

   // secure locks: or-in only, a zero never clears one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         locks_q <= 3'h0;
      end else if (commit && op == `FSC_OP_WR2) begin
         locks_q <= locks_q | data[`FSC_SR2_LOCK_LO +: 3];
      end
   end

   // secure area check answered one cycle after the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_wr_refused <= 1'b0;
      end else begin
         sec_wr_refused <= sec_wr_req & (sec_area_sel != 2'h0)
            & locks_q[sec_area_sel - 2'h1];
      end
   end

   // four-line enable and command mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         four_q <= 1'b0;
         quad_q <= 1'b0;
      end else begin
         if (commit && op == `FSC_OP_WR2) begin
            four_q <= data[`FSC_SR2_FOUR] | quad_q;
         end
         if (pin_rst) begin
            quad_q <= 1'b0;
         end else if (single && op == `FSC_OP_QUAD_ON && four_q) begin
            quad_q <= 1'b1;
         end else if (single && op == `FSC_OP_QUAD_OFF) begin
            quad_q <= 1'b0;
         end
      end
   end

   // third register fields; power-on width only via 11h after 06h
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pon_w_q <= 1'b0;
         str_q <= `FSC_STR_RST;
         dummy_q <= `FSC_DUMMY_RST;
         pinsel_q <= 1'b0;
      end else if (commit && op == `FSC_OP_WR3) begin
         pon_w_q <= data[`FSC_SR3_PON_W];
         str_q <= data[`FSC_SR3_STR_LO +: 2];
         dummy_q <= data[`FSC_SR3_DUMMY_LO +: 2];
         pinsel_q <= data[`FSC_SR3_PINSEL];
      end
   end

   // active width: reloaded from the power-on bit by any reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_w_q <= 1'b0; // power-on bit is zero here too
      end else if (pin_rst) begin
         act_w_q <= pon_w_q;
      end else if (single && op == `FSC_OP_ADDR4) begin
         act_w_q <= 1'b1;
      end else if (single && op == `FSC_OP_ADDR3) begin
         act_w_q <= 1'b0;
      end
   end

   // internal write cycle starts only for an accepted write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_cycle_start <= 1'b0;
      end else begin
         write_cycle_start <= commit;
      end
   end

   // dummy counts per read family
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dummy_fast <= `FSC_DUMMY_8;
         dummy_dual_io <= `FSC_DUMMY_4;
         dummy_quad_io <= `FSC_DUMMY_6;
      end else begin
         dummy_fast <= `FSC_DUMMY_8;
         dummy_dual_io <= dummy_q[0] ? `FSC_DUMMY_8 : `FSC_DUMMY_4;
         unique case (dummy_q)
            2'b00: dummy_quad_io <= `FSC_DUMMY_6;
            2'b01: dummy_quad_io <= `FSC_DUMMY_4;
            2'b10: dummy_quad_io <= `FSC_DUMMY_8;
            2'b11: dummy_quad_io <= `FSC_DUMMY_10;
         endcase
      end
   end

   // configuration views
   assign drive_strength = str_q;
   assign four_byte_addr = act_w_q;
   assign four_line_en = four_q;
   assign quad_cmd_mode = quad_q;
endmodule // fsc_device

// ===== design/fsc_host.sv
// Purpose: host controller end: APB orders to serial link frames
// Assumes: one frame at a time; sck made by dividing pclk
// Notes: orders written while busy are dropped
`timescale 1ns/1ps
`include "fsc_cfg.svh"
module fsc_host (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link
   fsc_link_if.host link
);
   fsc_pkg::fsc_host_st_e st_q;
   logic [15:0] tx_q;
   logic [7:0] rx_q;
   logic [17:0] cmd_q;
   logic [4:0] nbits_q, cnt_q;
   logic [3:0] div_q;
   logic sck_q, cs_n_q, guard_q, pause_q, miso_s;
   logic wr, tick, start, mapped;

   fsc_sync #(.W(1)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(link.miso),
      .dout(miso_s)
   );

   // zero-wait slave; unmapped offsets answer with an error
   assign pready = 1'b1;
   assign mapped = paddr == `FSC_REG_CMD || paddr == `FSC_REG_STAT || paddr == `FSC_REG_PINS;
   assign pslverr = psel & penable & ~mapped;
   assign wr = psel & penable & pwrite;
   assign start = wr && paddr == `FSC_REG_CMD && st_q == fsc_pkg::FSC_IDLE;
   // two frame lengths only, 8 or 16 bits: no array reads, so no dummy clocks to match
   assign tick = div_q == 4'(`FSC_SCK_HALF - 1);

   // read data taken in the setup cycle so it stands from a flop; the image is
   // one cycle old, which a busy poll simply absorbs by reading again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         unique case (paddr)
            `FSC_REG_CMD: prdata <= {14'h0000, cmd_q};
            `FSC_REG_STAT: prdata <= {16'h0000, rx_q, 7'h00, st_q != fsc_pkg::FSC_IDLE};
            `FSC_REG_PINS: prdata <= {30'h0000_0000, pause_q, guard_q};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // pin levels for guard and pause lines
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         guard_q <= 1'b1;
         pause_q <= 1'b1;
      end else if (wr && paddr == `FSC_REG_PINS) begin
         guard_q <= pwdata[0];
         pause_q <= pwdata[1];
      end
   end

   // frame sequencer; prefix and enable frames come as separate orders, so
   // software keeps their order and sets four-line enable before 38h
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= fsc_pkg::FSC_IDLE;
         cmd_q <= 18'h0_0000;
         tx_q <= 16'h0000;
         rx_q <= 8'h00;
         nbits_q <= 5'h00;
         cnt_q <= 5'h00;
         div_q <= 4'h0;
         sck_q <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         div_q <= (tick || st_q == fsc_pkg::FSC_IDLE) ? 4'h0 : div_q + 4'h1;
         unique case (st_q)
            fsc_pkg::FSC_IDLE: begin
               if (start) begin
                  cmd_q <= pwdata[17:0];
                  // short orders put the opcode first; bytes go out as given
                  tx_q <= pwdata[`FSC_CMD_LONG] ? pwdata[15:0] : {pwdata[7:0], 8'h00};
                  nbits_q <= pwdata[`FSC_CMD_LONG] ? `FSC_BITS_WR : `FSC_BITS_OP;
                  cnt_q <= 5'h00;
                  cs_n_q <= 1'b0;
                  st_q <= fsc_pkg::FSC_SHIFT;
               end
            end
            fsc_pkg::FSC_SHIFT: begin
               if (tick) begin
                  sck_q <= ~sck_q;
                  if (sck_q) begin
                     rx_q <= {rx_q[6:0], miso_s}; // sample at end of high phase
                     tx_q <= {tx_q[14:0], 1'b0};
                     cnt_q <= cnt_q + 5'h01;
                     if (cnt_q + 5'h01 == nbits_q) begin
                        st_q <= fsc_pkg::FSC_TAIL;
                     end
                  end
               end
            end
            fsc_pkg::FSC_TAIL: begin
               if (tick) begin
                  if (cs_n_q) begin
                     st_q <= fsc_pkg::FSC_IDLE;
                  end
                  cs_n_q <= 1'b1;
               end
            end
            default: st_q <= fsc_pkg::FSC_IDLE;
         endcase
      end
   end

   // link outputs straight from flops
   assign link.sck = sck_q;
   assign link.cs_n = cs_n_q;
   assign link.mosi = tx_q[15];
   assign link.guard_n = guard_q;
   assign link.pause_n = pause_q;
endmodule // fsc_host

// ===== verif/fsc_link_monitor.sv
// Purpose: wire checks on the link between host and flash ends
// Assumes: host divides pclk so each sck half lasts 8 cycles
// Notes: sees only the interface wires, one clock domain
`timescale 1ns/1ps
module fsc_link_monitor (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link wires
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic guard_n,
   input wire logic pause_n
);
   logic [9:0] low_q;
   // frame length; a frame that never closes would hang the host
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_q <= 10'h000;
      end else begin
         low_q <= cs_n ? 10'h000 : low_q + 10'h001;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_sck_idle; cs_n |-> !sck; endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("sck moves outside frame");
   property p_sck_high; $rose(sck) |-> sck [*8] ##1 !sck; endproperty
   a_sck_high: assert property (p_sck_high) else $error("sck high half wrong");
   property p_sck_low; $fell(sck) |-> !sck [*8]; endproperty
   a_sck_low: assert property (p_sck_low) else $error("sck low half short");
   property p_mosi_hold; sck && $past(sck) |-> $stable(mosi); endproperty
   a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved, sck high");
   property p_miso_hold; sck && $past(sck) |-> $stable(miso); endproperty
   a_miso_hold: assert property (p_miso_hold) else $error("miso moved, sck high");
   property p_cs_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
   a_cs_gap: assert property (p_cs_gap) else $error("frame gap short");
   property p_cs_lead; $fell(cs_n) |-> !sck [*8]; endproperty
   a_cs_lead: assert property (p_cs_lead) else $error("sck rose too early");
   property p_frame_len; !cs_n |-> low_q < 10'h12C; endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame too long");
endmodule // fsc_link_monitor

// ===== verif/flash_status_config_fields_tb.sv
// Purpose: self-checking bench for the host and flash link ends
// Assumes: apb answers at once, one frame at a time
// Notes: driver queues notes, a watcher compares seen values
`timescale 1ns/1ps
`include "fsc_cfg.svh"
module flash_status_config_fields_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [1:0] sel = 2'h0;
   logic req = 1'b0;
   logic refused;
   logic four_b;
   logic fle;
   logic qmode;
   logic wcs;
   logic [1:0] str;
   logic [3:0] d_f;
   logic [3:0] d_d;
   logic [3:0] d_q;
   logic [3:0] qtab [4] = '{4'h6, 4'h4, 4'h8, 4'hA};
   logic [31:0] exp_q [$];
   logic [31:0] obs = 32'h0;
   logic obs_v = 1'b0;
   logic [31:0] v;
   logic err;
   int n_fail = 0;
   int checks_done = 0;
   int wcs_n = 0;
   fsc_link_if link ();
   fsc_host u_fsc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link.host));
   fsc_device u_fsc_device (.pclk(pclk), .presetn(presetn), .link(link.dev),
      .sec_area_sel(sel), .sec_wr_req(req), .sec_wr_refused(refused), .drive_strength(str),
      .four_byte_addr(four_b), .four_line_en(fle), .quad_cmd_mode(qmode), .dummy_fast(d_f),
      .dummy_dual_io(d_d), .dummy_quad_io(d_q), .write_cycle_start(wcs));
   fsc_link_monitor u_fsc_link_monitor (.pclk(pclk), .presetn(presetn), .sck(link.sck),
      .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .guard_n(link.guard_n),
      .pause_n(link.pause_n));
   // clock, and a count of write cycles the flash end starts
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (wcs === 1'b1) wcs_n++;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] want);
      checks_done++;
      if (got !== want) begin
         n_fail++;
         $display("FAIL %0t got %h want %h", $time, got, want);
      end
   endtask
   // the watcher takes the oldest note whenever a value is seen
   always @(posedge pclk) begin
      if (obs_v) cmp(obs, exp_q.pop_front());
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      exp_q.push_back(want);
      obs <= got;
      obs_v <= 1'b1;
      @(posedge pclk);
      obs_v <= 1'b0;
      @(posedge pclk);
   endtask
   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      v = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // start a frame and poll busy; the watchdog bounds a hang
   task automatic send(input logic [31:0] c);
      apb(1'b1, `FSC_REG_CMD, c);
      v = 32'h1;
      while (v[0] !== 1'b0) apb(1'b0, `FSC_REG_STAT, 32'h0);
   endtask
   task automatic sr(input logic [7:0] op, input logic [7:0] want);
      send({16'h0001, op, 8'h00});
      apb(1'b0, `FSC_REG_STAT, 32'h0);
      chk({24'h0, v[15:8]}, {24'h0, want});
   endtask
   task automatic wr(input logic [7:0] op, input logic [7:0] d);
      send({24'h0, `FSC_OP_WREN});
      send({16'h0001, op, d});
   endtask
   task automatic area(input logic want);
      logic seen;
      seen = 1'b0;
      req <= 1'b1;
      @(posedge pclk);
      req <= 1'b0;
      repeat (2) begin
         @(negedge pclk);
         seen = seen | refused;
      end
      chk({31'h0, seen}, {31'h0, want});
   endtask
   // main sequence
   initial begin
      int n;
      logic [1:0] dc;
      v = $urandom(32'h7442_b4be);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `FSC_REG_PINS, 32'h0);
      chk(v, 32'h3);
      apb(1'b0, 8'h0C, 32'h0);
      chk({err, v[30:0]}, 32'h8000_0000);
      sr(`FSC_OP_RD2, 8'h00);
      sr(`FSC_OP_RD3, 8'h20);
      chk(32'({str, d_f, d_d, d_q}), 32'({2'h1, 4'h8, 4'h4, 4'h6}));
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         dc = ~i[1:0];
         v = $urandom;
         n = wcs_n;
         wr(`FSC_OP_WR3, {1'b0, i[1:0], v[0], dc, 1'b0, v[1]});
         sr(`FSC_OP_RD3, {1'b0, i[1:0], 1'b0, dc, 2'b00});
         sr(`FSC_OP_RD1, 8'h00);
         chk(32'(wcs_n - n), 32'h1);
         chk(32'({str, d_q, d_f, d_d}), 32'({i[1:0], qtab[dc], 4'h8, dc[0] ? 4'h8 : 4'h4}));
      end
      n = wcs_n;
      send({16'h0001, `FSC_OP_WR3, 8'h40});
      sr(`FSC_OP_RD3, 8'h60);
      chk(32'(wcs_n - n), 32'h0);
      $display("test fields done");
      send({24'h0, `FSC_OP_QUAD_ON});
      chk({31'h0, qmode}, 32'h0);
      wr(`FSC_OP_WR1, 8'h80);
      sr(`FSC_OP_RD1, 8'h80);
      apb(1'b1, `FSC_REG_PINS, 32'h2);
      n = wcs_n;
      wr(`FSC_OP_WR3, 8'h40);
      chk(32'({str, 8'(wcs_n - n)}), 32'({2'h3, 8'h0}));
      apb(1'b1, `FSC_REG_PINS, 32'h3);
      wr(`FSC_OP_WR3, 8'h20);
      chk({30'h0, str}, 32'h1);
      wr(`FSC_OP_WR2, 8'h02);
      apb(1'b1, `FSC_REG_PINS, 32'h2);
      wr(`FSC_OP_WR3, 8'h40);
      chk(32'({fle, str}), 32'h6);
      send({24'h0, `FSC_OP_QUAD_ON});
      wr(`FSC_OP_WR2, 8'h00);
      wr(`FSC_OP_WR3, 8'h00);
      chk(32'({qmode, fle, str}), 32'hC);
      send({24'h0, `FSC_OP_QUAD_OFF});
      wr(`FSC_OP_WR2, 8'h00);
      chk(32'({qmode, fle}), 32'h0);
      apb(1'b1, `FSC_REG_PINS, 32'h3);
      wr(`FSC_OP_WR1, 8'h00);
      $display("test guard done");
      send({24'h0, `FSC_OP_SUSP});
      sr(`FSC_OP_RD2, 8'h80);
      send({24'h0, `FSC_OP_RESUME});
      sr(`FSC_OP_RD2, 8'h00);
      for (int i = 1; i < 4; i++) begin
         sel <= i[1:0];
         area(1'b0);
         wr(`FSC_OP_WR2, 8'h44 | 8'(8'h04 << i));
         sr(`FSC_OP_RD2, 8'(((1 << i) - 1) << 3));
         area(1'b1);
      end
      $display("test locks done");
      send({24'h0, `FSC_OP_SUSP});
      wr(`FSC_OP_WR2, 8'h01);
      n = wcs_n;
      wr(`FSC_OP_WR3, 8'h60);
      chk(32'(wcs_n - n), 32'h0);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      sr(`FSC_OP_RD2, 8'h00);
      wr(`FSC_OP_WR3, 8'h82);
      sr(`FSC_OP_RD3, 8'h82);
      chk({31'h0, four_b}, 32'h0);
      apb(1'b1, `FSC_REG_PINS, 32'h1);
      apb(1'b1, `FSC_REG_PINS, 32'h3);
      repeat (4) @(posedge pclk);
      chk({31'h0, four_b}, 32'h1);
      sr(`FSC_OP_RD3, 8'h83);
      $display("test power done");
      send({24'h0, `FSC_OP_PFX1});
      send({24'h0, `FSC_OP_PFX2});
      wr(`FSC_OP_WR3, 8'h02);
      n = wcs_n;
      wr(`FSC_OP_WR3, 8'h60);
      chk(32'(wcs_n - n), 32'h0);
      $display("test prefix done");
      sr(`FSC_OP_RD1, 8'h02);
      send({24'h0, `FSC_OP_WRDI});
      sr(`FSC_OP_RD1, 8'h00);
      apb(1'b1, `FSC_REG_PINS, 32'h1);
      send({24'h0, `FSC_OP_WREN});
      apb(1'b1, `FSC_REG_PINS, 32'h3);
      sr(`FSC_OP_RD1, 8'h00);
      send({24'h0, `FSC_OP_ADDR3});
      chk({31'h0, four_b}, 32'h0);
      $display("test pins done");
      final_report();
   end
   // watchdog; the run needs some 18000 cycles
   initial begin
      repeat (60000) @(posedge pclk);
      n_fail++;
      final_report();
   end
endmodule // flash_status_config_fields_tb
